//--- inc/rtctrm_pkg.sv
// constants, types and register map of the rate-trim corrector
// assumes an apb master and a synchronous 32.768 kHz tick pulse
package rtctrm_pkg;

    // -------------------------------------------------------------
    // register indices, byte address is four times the index
    // -------------------------------------------------------------
    localparam logic [7:0] IDX_RATE_TRIM  = 8'h24;
    localparam logic [7:0] IDX_OSC_CTRL   = 8'h25;
    localparam logic [7:0] IDX_IRQ_EN_A   = 8'h29;
    localparam logic [7:0] IDX_IRQ_EN_B   = 8'h2a;
    localparam logic [7:0] IDX_EVT_STATUS = 8'h40;
    localparam logic [7:0] IDX_EVT_MASK   = 8'h41;
    localparam logic [7:0] IDX_TRIM_STATE = 8'h42;

    // -------------------------------------------------------------
    // field positions and reset values
    // -------------------------------------------------------------
    localparam int unsigned CADENCE_BIT  = 6;
    localparam int unsigned TRIM_IEN_BIT = 5;
    localparam int unsigned EVT_CORR_BIT = 0;
    localparam int unsigned EVT_TRIG_BIT = 1;
    localparam int unsigned EVT_W        = 2;
    localparam logic [7:0] RATE_TRIM_RST = 8'h00;
    localparam logic [7:0] OSC_CTRL_RST  = 8'h00;
    localparam logic       IRQ_EN_RST    = 1'b0;
    localparam logic [1:0] EVT_RST       = 2'h0;

    // -------------------------------------------------------------
    // timebase
    // -------------------------------------------------------------
    localparam int unsigned XTAL_HZ           = 32768;
    localparam int unsigned SEC_PER_MIN       = 60;
    localparam int unsigned MIN_PER_HOUR      = 60;
    localparam int unsigned NORM_PERIOD_HOURS = 4;
    localparam int unsigned FAST_PERIOD_MIN   = 8;
    localparam logic [5:0] SEC_LAST = 6'(SEC_PER_MIN - 1);
    localparam logic [5:0] MIN_LAST = 6'(MIN_PER_HOUR - 1);
    localparam logic [1:0] HR4_LAST = 2'(NORM_PERIOD_HOURS - 1);
    localparam logic [2:0] M8_LAST  = 3'(FAST_PERIOD_MIN - 1);

    // -------------------------------------------------------------
    // types
    // -------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_RUN} rtctrm_state_t;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [3:0]  strb;
        logic [31:0] wdata;
    } rtctrm_req_t;

endpackage

//--- rtl/rtctrm_cnt.sv
// wrapping counter used for the seconds, minutes and period counters
// assumes one clock, enable pulses and an asynchronous low reset
module rtctrm_cnt
#(
    parameter int unsigned  W   = 6,
    parameter logic [W-1:0] MAX = '1
)
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         en,
    output logic [W-1:0] value,
    output logic         wrap
);

    assign wrap = (value == MAX);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            value <= '0;
        else if (en)
            value <= wrap ? '0 : value + W'(1);
    end

endmodule

//--- rtl/rtctrm_top.sv
// rate-trim corrector of a real-time clock with apb register access
// assumes xtal_tick is a one-cycle pulse, synchronous to pclk
//
// Summary of operation
// - trim is signed 8 bits, zero means none
// - normal cadence triggers every four hours
// - fast cadence triggers every eight minutes
// - cadence select is oscillator control bit 6
// - correction changes second length, not oscillator
// - normal: one pulse per minute until done
// - normal pulses spill over at most three hours
// - every applied pulse is a visible event
// - fast: one pulse per second, three minutes max
// - enabled interrupt pulse per correction, each output
module rtctrm_top
#(
    parameter int unsigned PRESCALE = rtctrm_pkg::XTAL_HZ
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  pstrb,
    input  wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic        pready,
    output logic        pslverr,
    input  wire logic        xtal_tick,
    output logic        corr_pulse,
    output logic        irq,
    output logic        irq_out_a_n,
    output logic        irq_out_b_n
);

    localparam int unsigned PW = $clog2(PRESCALE);

    // ---------------------------------------------------------------
    // apb decode
    // ---------------------------------------------------------------
    rtctrm_pkg::rtctrm_req_t req;
    logic [7:0]  idx;
    logic        in_range;
    logic        sel_trim;
    logic        sel_osc;
    logic        sel_ena;
    logic        sel_enb;
    logic        sel_stat;
    logic        sel_mask;
    logic        sel_state;
    logic        mapped;
    logic        setup;
    logic        wr;
    logic [31:0] rd_data;

    assign req       = '{addr: paddr, write: pwrite, strb: pstrb,
                         wdata: pwdata};
    assign idx       = req.addr[9:2];
    assign in_range  = (req.addr[11:10] == 2'h0) && (req.addr[1:0] == 2'h0);
    assign sel_trim  = in_range && (idx == rtctrm_pkg::IDX_RATE_TRIM);
    assign sel_osc   = in_range && (idx == rtctrm_pkg::IDX_OSC_CTRL);
    assign sel_ena   = in_range && (idx == rtctrm_pkg::IDX_IRQ_EN_A);
    assign sel_enb   = in_range && (idx == rtctrm_pkg::IDX_IRQ_EN_B);
    assign sel_stat  = in_range && (idx == rtctrm_pkg::IDX_EVT_STATUS);
    assign sel_mask  = in_range && (idx == rtctrm_pkg::IDX_EVT_MASK);
    assign sel_state = in_range && (idx == rtctrm_pkg::IDX_TRIM_STATE);
    assign mapped    = sel_trim | sel_osc | sel_ena | sel_enb | sel_stat
                     | sel_mask | sel_state;
    assign setup     = psel & ~penable;
    assign wr        = psel & penable & pready & req.write & req.strb[0]
                     & mapped;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0] trim_q;
    logic [7:0] osc_q;
    logic       en_a_q;
    logic       en_b_q;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] mask_q;
    logic [1:0] events;
    logic       cadence;

    assign cadence  = osc_q[rtctrm_pkg::CADENCE_BIT];
    assign status_d = (status_q & ~((wr & sel_stat) ? req.wdata[1:0]
                                                    : 2'h0)) | events;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trim_q   <= rtctrm_pkg::RATE_TRIM_RST;
            osc_q    <= rtctrm_pkg::OSC_CTRL_RST;
            en_a_q   <= rtctrm_pkg::IRQ_EN_RST;
            en_b_q   <= rtctrm_pkg::IRQ_EN_RST;
            mask_q   <= rtctrm_pkg::EVT_RST;
            status_q <= rtctrm_pkg::EVT_RST;
        end
        else
        begin
            if (wr && sel_trim)
                trim_q <= req.wdata[7:0];
            if (wr && sel_osc)
                osc_q <= req.wdata[7:0];
            if (wr && sel_ena)
                en_a_q <= req.wdata[rtctrm_pkg::TRIM_IEN_BIT];
            if (wr && sel_enb)
                en_b_q <= req.wdata[rtctrm_pkg::TRIM_IEN_BIT];
            if (wr && sel_mask)
                mask_q <= req.wdata[1:0];
            status_q <= status_d;
        end
    end

    // ---------------------------------------------------------------
    // apb answer, one cycle after setup
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup && !req.write) ? rd_data : 32'h0000_0000;
        end
    end

    // ---------------------------------------------------------------
    // prescaler and time counters
    // ---------------------------------------------------------------
    logic [PW-1:0] presc_q;
    logic          stretch_q;
    logic          presc_last;
    logic          sec_roll;
    logic          new_min;
    logic          new_hour;
    logic [5:0]    sec_val;
    logic [5:0]    min_val;
    logic [1:0]    hr4_val;
    logic [2:0]    m8_val;
    logic          sec_wrap;
    logic          min_wrap;
    logic          hr4_wrap;
    logic          m8_wrap;
    logic          corr_now;
    logic          shorten_sel;

    assign presc_last = (presc_q == PW'(PRESCALE - 1));
    assign sec_roll   = xtal_tick & ~stretch_q & presc_last;
    assign new_min    = sec_roll & sec_wrap;
    assign new_hour   = new_min & min_wrap;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            presc_q   <= '0;
            stretch_q <= 1'b0;
        end
        else if (xtal_tick)
        begin
            if (stretch_q)
                stretch_q <= 1'b0;
            else if (presc_last)
            begin
                presc_q   <= (corr_now & shorten_sel) ? PW'(1) : '0;
                stretch_q <= corr_now & ~shorten_sel;
            end
            else
                presc_q <= presc_q + PW'(1);
        end
    end

    rtctrm_cnt #(.W(6), .MAX(rtctrm_pkg::SEC_LAST)) u_sec
    (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (sec_roll),
        .value (sec_val),
        .wrap  (sec_wrap)
    );

    rtctrm_cnt #(.W(6), .MAX(rtctrm_pkg::MIN_LAST)) u_min
    (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (new_min),
        .value (min_val),
        .wrap  (min_wrap)
    );

    rtctrm_cnt #(.W(2), .MAX(rtctrm_pkg::HR4_LAST)) u_hr4
    (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (new_hour),
        .value (hr4_val),
        .wrap  (hr4_wrap)
    );

    rtctrm_cnt #(.W(3), .MAX(rtctrm_pkg::M8_LAST)) u_m8
    (
        .clk   (pclk),
        .rst_n (presetn),
        .en    (new_min),
        .value (m8_val),
        .wrap  (m8_wrap)
    );

    // ---------------------------------------------------------------
    // correction sequencer
    // ---------------------------------------------------------------
    rtctrm_pkg::rtctrm_state_t state_q;
    rtctrm_pkg::rtctrm_state_t state_d;
    logic [7:0] left_q;
    logic [7:0] left_d;
    logic [7:0] mag;
    logic       run_fast_q;
    logic       shorten_q;
    logic       norm_trig;
    logic       fast_trig;
    logic       trig;
    logic       step;

    assign norm_trig   = new_hour & hr4_wrap;
    assign fast_trig   = new_min & m8_wrap;
    assign trig        = cadence ? fast_trig : norm_trig;
    assign mag         = trim_q[7] ? (8'h00 - trim_q) : trim_q;
    assign shorten_sel = trig ? ~trim_q[7] : shorten_q;
    assign step        = (state_q == rtctrm_pkg::ST_RUN)
                       & (run_fast_q ? sec_roll : new_min);
    assign corr_now    = trig ? (mag != 8'h00) : step;
    assign events      = {trig, corr_now};

    always_comb
    begin
        state_d = state_q;
        left_d  = left_q;
        if (trig)
        begin
            left_d  = (mag != 8'h00) ? mag - 8'h01 : 8'h00;
            state_d = (left_d != 8'h00) ? rtctrm_pkg::ST_RUN
                                        : rtctrm_pkg::ST_IDLE;
        end
        else if (step)
        begin
            left_d  = left_q - 8'h01;
            state_d = (left_d != 8'h00) ? rtctrm_pkg::ST_RUN
                                        : rtctrm_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= rtctrm_pkg::ST_IDLE;
            left_q     <= 8'h00;
            run_fast_q <= 1'b0;
            shorten_q  <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            left_q  <= left_d;
            if (trig)
            begin
                run_fast_q <= cadence;
                shorten_q  <= ~trim_q[7];
            end
        end
    end

    // ---------------------------------------------------------------
    // event outputs
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            corr_pulse  <= 1'b0;
            irq         <= 1'b0;
            irq_out_a_n <= 1'b1;
            irq_out_b_n <= 1'b1;
        end
        else
        begin
            corr_pulse  <= corr_now;
            irq         <= |(status_d & mask_q);
            irq_out_a_n <= ~(corr_now & en_a_q);
            irq_out_b_n <= ~(corr_now & en_b_q);
        end
    end

    // ---------------------------------------------------------------
    // read mux
    // ---------------------------------------------------------------
    assign rd_data =
        sel_trim  ? {24'h00_0000, trim_q} :
        sel_osc   ? {24'h00_0000, osc_q} :
        sel_ena   ? {26'h000_0000, en_a_q, 5'h00} :
        sel_enb   ? {26'h000_0000, en_b_q, 5'h00} :
        sel_stat  ? {30'h0000_0000, status_q} :
        sel_mask  ? {30'h0000_0000, mask_q} :
        sel_state ? {21'h00_0000, state_q == rtctrm_pkg::ST_RUN,
                     run_fast_q, shorten_q, left_q} :
        32'h0000_0000;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    trim_zero_a: assert property (
        trig && trim_q == 8'h00 |=> !corr_pulse && left_q == 8'h00)
        else $error("zero trim produced a correction");
    trim_load_a: assert property (
        trig && trim_q == 8'h80 |=> left_q == 8'h7f && corr_pulse)
        else $error("most negative trim loaded wrong count");
    norm_period_a: assert property (
        trig && !cadence |-> hr4_val == 2'h3 && min_val == 6'h3b
                             && sec_val == 6'h3b)
        else $error("normal trigger off the four-hour boundary");
    fast_period_a: assert property (
        trig && cadence |-> m8_val == 3'h7 && sec_val == 6'h3b)
        else $error("fast trigger off the eight-minute boundary");
    cadence_write_a: assert property (
        wr && sel_osc |=> cadence == $past(pwdata[6]))
        else $error("cadence bit not taken from bit 6");
    second_trim_a: assert property (
        corr_now && shorten_sel |=> presc_q == PW'(1) && !stretch_q)
        else $error("shortened second not applied");
    second_stretch_a: assert property (
        corr_now && !shorten_sel |=> stretch_q && presc_q == '0)
        else $error("lengthened second not applied");
    norm_step_a: assert property (
        corr_now && !trig && !run_fast_q |-> new_min)
        else $error("normal correction off the minute");
    norm_span_a: assert property (
        state_q == rtctrm_pkg::ST_RUN && !run_fast_q |-> hr4_val <= 2'h2)
        else $error("normal run spilled past third hour");
    pulse_seen_a: assert property (
        corr_now |=> corr_pulse && status_q[rtctrm_pkg::EVT_CORR_BIT])
        else $error("correction not reported");
    fast_span_a: assert property (
        state_q == rtctrm_pkg::ST_RUN && run_fast_q |-> m8_val <= 3'h2
        && (!corr_now || trig || sec_roll))
        else $error("fast run off schedule");
    irq_pulse_a: assert property (
        corr_now && en_a_q |=> !irq_out_a_n ##1 (irq_out_a_n || corr_pulse))
        else $error("interrupt pulse on output a wrong");
    sample_hold_a: assert property (
        !trig && state_q == rtctrm_pkg::ST_RUN
        |=> $stable(run_fast_q) && $stable(shorten_q))
        else $error("cadence or sign changed mid-run");

endmodule

//--- testbench/tb.sv
// self-checking bench of the rate-trim corrector, apb side and outputs
// assumes rtctrm_pkg is compiled first and prescale shortened to 3
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // -------------------------------------------------------------
    // signals and notes
    // -------------------------------------------------------------
    localparam int unsigned PS    = 3;
    localparam int          LIMIT = 50000;
    localparam int          SEC_T    = rtctrm_pkg::SEC_PER_MIN * PS;
    localparam int          FAST_GAP = rtctrm_pkg::FAST_PERIOD_MIN * SEC_T;
    localparam int          NORM_GAP = rtctrm_pkg::NORM_PERIOD_HOURS
                                     * rtctrm_pkg::MIN_PER_HOUR * SEC_T
                                     - 2 * FAST_GAP + 3;

    typedef struct {
        logic        err;
        logic        rd;
        logic [31:0] d;
    } rtctrm_tb_note_t;

    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [3:0]  pstrb;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        xtal_tick = 1'b0;
    logic        corr_pulse;
    logic        irq;
    logic        irq_out_a_n;
    logic        irq_out_b_n;
    logic        tick_en;
    logic        exp_a;
    logic        exp_b;
    int          fail_count;
    int          comparisons;
    int          cyc = 0;
    int          corr_n;
    int          corr_t[$];
    rtctrm_tb_note_t notes[$];
    logic [31:0] r;

    rtctrm_top #(.PRESCALE(PS)) dut (
        .pclk        (pclk),
        .presetn     (presetn),
        .paddr       (paddr),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .pstrb       (pstrb),
        .pwdata      (pwdata),
        .prdata      (prdata),
        .pready      (pready),
        .pslverr     (pslverr),
        .xtal_tick   (xtal_tick),
        .corr_pulse  (corr_pulse),
        .irq         (irq),
        .irq_out_a_n (irq_out_a_n),
        .irq_out_b_n (irq_out_b_n)
    );

    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one apb transfer, noting the expected answer first
    task automatic apb(input logic [7:0] idx, input logic w,
                       input logic [31:0] d, input logic [31:0] exp,
                       input logic err);
        rtctrm_tb_note_t n;
        n.err = err;
        n.rd  = ~w;
        n.d   = exp;
        notes.push_back(n);
        @(posedge pclk);
        psel    <= 1'b1;
        paddr   <= {2'b00, idx, 2'b00};
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_corr(input int n);
        int k;
        for (k = 0; k < LIMIT && corr_n < n; k++)
            @(posedge pclk);
    endtask

    // -------------------------------------------------------------
    // monitors
    // -------------------------------------------------------------
    always @(posedge pclk)
    begin
        rtctrm_tb_note_t n;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
        begin
            n = notes.pop_front();
            check("pslverr", {31'h0, pslverr}, {31'h0, n.err});
            if (n.rd)
                check("prdata", prdata, n.d);
        end
        if (corr_pulse === 1'b1)
        begin
            corr_n++;
            corr_t.push_back(cyc);
            check("irq_out_a_n", {31'h0, irq_out_a_n}, {31'h0, ~exp_a});
            check("irq_out_b_n", {31'h0, irq_out_b_n}, {31'h0, ~exp_b});
        end
    end

    // crystal tick on every pclk cycle once enabled
    always @(posedge pclk)
    begin
        xtal_tick <= tick_en;
        cyc       <= cyc + 1;
        if (cyc == LIMIT)
        begin
            fail_count++;
            results();
        end
    end

    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        presetn = 1'b0;
        paddr = 12'h000;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pstrb = 4'hf;
        pwdata = 32'h0000_0000;
        tick_en = 1'b0;
        exp_a = 1'b0;
        exp_b = 1'b0;
        fail_count = 0;
        comparisons = 0;
        corr_n = 0;
        void'($urandom(32'h5b40));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // reset values and unmapped access
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b0, 0, 32'h0000_0000, 1'b0);
        apb(rtctrm_pkg::IDX_OSC_CTRL, 1'b0, 0, 32'h0000_0000, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b0, 0, 32'h0000_0000, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_B, 1'b0, 0, 32'h0000_0000, 1'b0);
        apb(rtctrm_pkg::IDX_EVT_STATUS, 1'b0, 0, 32'h0000_0000, 1'b0);
        apb(8'h30, 1'b1, 32'h0000_00ff, 0, 1'b1);
        apb(8'h30, 1'b0, 0, 32'h0000_0000, 1'b1);
        // random readback of the trim and control bytes
        r = $urandom;
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b1, r, 0, 1'b0);
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b0, 0, {24'h0, r[7:0]}, 1'b0);
        r = $urandom;
        apb(rtctrm_pkg::IDX_OSC_CTRL, 1'b1, r, 0, 1'b0);
        apb(rtctrm_pkg::IDX_OSC_CTRL, 1'b0, 0, {24'h0, r[7:0]}, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b1, r, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b0, 0, r & 32'h0000_0020, 1'b0);
        // fast cadence, trim +2, output a only
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b1, 32'h0000_0002, 0, 1'b0);
        apb(rtctrm_pkg::IDX_OSC_CTRL, 1'b1, 32'h0000_0040, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b1, 32'h0000_0020, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_B, 1'b1, 32'h0000_0000, 0, 1'b0);
        apb(rtctrm_pkg::IDX_EVT_MASK, 1'b1, 32'h0000_0001, 0, 1'b0);
        exp_a = 1'b1;
        exp_b = 1'b0;
        tick_en <= 1'b1;
        wait_corr(2);
        check("gap_short", corr_t[1] - corr_t[0], PS - 1);
        repeat (20) @(posedge pclk);
        check("pulses_pos", corr_n, 2);
        check("irq_set", {31'h0, irq}, 32'h0000_0001);
        apb(rtctrm_pkg::IDX_EVT_STATUS, 1'b0, 0, 32'h0000_0003, 1'b0);
        apb(rtctrm_pkg::IDX_EVT_STATUS, 1'b1, 32'h0000_0003, 0, 1'b0);
        repeat (3) @(posedge pclk);
        check("irq_clr", {31'h0, irq}, 32'h0000_0000);
        apb(rtctrm_pkg::IDX_EVT_STATUS, 1'b0, 0, 32'h0000_0000, 1'b0);
        // trim -3 on output b, changed to +1 in mid-run
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b1, 32'h0000_00fd, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b1, 32'h0000_0000, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_B, 1'b1, 32'h0000_0020, 0, 1'b0);
        exp_a = 1'b0;
        exp_b = 1'b1;
        wait_corr(3);
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b1, 32'h0000_0001, 0, 1'b0);
        wait_corr(5);
        check("gap_long", corr_t[3] - corr_t[2], PS + 1);
        check("fast_period", corr_t[2] - corr_t[0], FAST_GAP - 2);
        repeat (40) @(posedge pclk);
        check("pulses_neg", corr_n, 5);
        check("irq_again", {31'h0, irq}, 32'h0000_0001);
        apb(rtctrm_pkg::IDX_EVT_MASK, 1'b1, 32'h0000_0000, 0, 1'b0);
        repeat (3) @(posedge pclk);
        check("irq_masked", {31'h0, irq}, 32'h0000_0000);
        // normal cadence, trim +2, both outputs
        apb(rtctrm_pkg::IDX_OSC_CTRL, 1'b1, 32'h0000_0000, 0, 1'b0);
        apb(rtctrm_pkg::IDX_RATE_TRIM, 1'b1, 32'h0000_0002, 0, 1'b0);
        apb(rtctrm_pkg::IDX_IRQ_EN_A, 1'b1, 32'h0000_0020, 0, 1'b0);
        exp_a = 1'b1;
        exp_b = 1'b1;
        wait_corr(7);
        check("norm_period", corr_t[5] - corr_t[2], NORM_GAP);
        check("gap_norm", corr_t[6] - corr_t[5], SEC_T - 1);
        repeat (200) @(posedge pclk);
        check("pulses_norm", corr_n, 7);
        results();
    end
endmodule
